// ===== anps_pkg.sv
// constants for the partner ability and expansion status registers
package anps_pkg;
   localparam int         ANPS_AW           = 5;
   localparam int         ANPS_DW           = 16;
   localparam logic [4:0] ANPS_ADDR_LPBA    = 5'h05;
   localparam logic [4:0] ANPS_ADDR_EXP     = 5'h06;
   localparam logic [4:0] ANPS_ADDR_LPNP    = 5'h08;
   // partner ability register fields
   localparam int         ANPS_LP_NP        = 15;
   localparam int         ANPS_LP_ACK       = 14;
   localparam int         ANPS_LP_RF        = 13;
   localparam int         ANPS_LP_ASYM_HI   = 12;
   localparam int         ANPS_LP_ASYM_LO   = 11;
   localparam int         ANPS_LP_PAUSE     = 10;
   localparam int         ANPS_LP_T4        = 9;
   localparam int         ANPS_LP_TXFD      = 8;
   localparam int         ANPS_LP_TX        = 7;
   localparam int         ANPS_LP_10FD      = 6;
   localparam int         ANPS_LP_10        = 5;
   localparam int         ANPS_LP_SEL_HI    = 4;
   localparam int         ANPS_LP_SEL_LO    = 0;
   localparam logic [4:0] ANPS_SEL_8023     = 5'h01;
   localparam logic [4:0] ANPS_SEL_8029     = 5'h02;
   localparam logic [15:0] ANPS_LPBA_RST    = 16'h0000;
   localparam logic [15:0] ANPS_LPNP_RST    = 16'h0000;
   // expansion register fields
   localparam int         ANPS_EX_BASE      = 5;
   localparam int         ANPS_EX_PDF       = 4;
   localparam int         ANPS_EX_LPNPA     = 3;
   localparam int         ANPS_EX_NPA       = 2;
   localparam int         ANPS_EX_PRX       = 1;
   localparam int         ANPS_EX_LPANA     = 0;
   localparam logic [9:0] ANPS_EX_RSVD      = 10'h000;
   localparam logic       ANPS_NPA_RST      = 1'b1;
endpackage

// ===== anps_latch_high.sv
// one latching-high status bit, cleared by a read of its register
`timescale 1ns/1ps
module anps_latch_high (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output logic      q_o
);
   logic q_reg;
   logic q_next;
   // set wins so an event in the read cycle is never lost
   assign q_next = set_i | (q_reg & ~clr_i);
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         q_reg <= 1'b0;
      end else begin
         q_reg <= q_next;
      end
   end
   assign q_o = q_reg;
endmodule

// ===== anps_status_regs.sv
// partner base page ability and expansion status registers of one port
//
// How it works
// (R01) partner next-page bit 15 follows received base page.
// (R02) partner acknowledge bit 14 follows received base page.
// (R03) asymmetric pause field bits 12:11 from partner, reset zero.
// (R04) symmetric pause bit 10 from partner, reset zero.
// (R05) bit 9 shows partner 100BASE-T4 ability.
// (R06) bit 8 shows partner 100BASE-TX full duplex.
// (R07) bit 7 shows partner 100BASE-TX half duplex.
// (R08) bit 6 shows partner 10BASE-T full duplex.
// (R09) bit 5 shows partner 10BASE-T.
// (R10) selector code in bits 4:0, resets to zero.
// (R11) only base pages load register 5; next pages go to register 8.
// (R12) expansion bit 5 latches base_page, only with alternate next page on.
// (R13) expansion bit 4 latches parallel detection fault until read.
// (R14) expansion bit 3 shows partner next-page ability.
// (R15) expansion bit 2 shows local next-page ability, resets to one.
// (R16) page received latches high on every new code word.
// (R17) reading expansion register clears page received.
// (R18) alternate mode also clears it on page_rx falling or tx disable rising.
// (R19) expansion bit 0 shows partner auto-negotiation ability.
// (R20) expansion bits 15:6 read zero.
// (R21) latching bits clear when their register is read.
// (R22) writes to both registers are ignored.
`timescale 1ns/1ps
module anps_status_regs
   import anps_pkg::*;
#(
   parameter logic LOCAL_NP_ABLE = ANPS_NPA_RST
) (
   input  wire logic                         core_clk_i,
   input  wire logic                         rst_n_i,
   // management access
   input  wire logic                         mgmt_rd_i,
   input  wire logic                         mgmt_wr_i,
   input  wire logic [anps_pkg::ANPS_AW-1:0] mgmt_addr_i,
   input  wire logic [anps_pkg::ANPS_DW-1:0] mgmt_wdata_i,
   output logic      [anps_pkg::ANPS_DW-1:0] mgmt_rdata_o,
   output logic                              mgmt_hit_o,
   // arbitration side
   input  wire logic                         page_valid_i,
   input  wire logic                         page_is_next_i,
   input  wire logic [anps_pkg::ANPS_DW-1:0] page_word_i,
   input  wire logic                         base_page_i,
   input  wire logic                         pd_fault_i,
   input  wire logic                         lp_np_able_i,
   input  wire logic                         lp_an_able_i,
   input  wire logic                         mr_page_rx_i,
   input  wire logic                         transmit_disable_i,
   input  wire logic                         alt_np_enable_i,
   // received next page to the separate partner next-page store
   output logic      [anps_pkg::ANPS_DW-1:0] lp_next_page_o,
   output logic                              lp_next_page_load_o
);
   import anps_pkg::*;

   logic [ANPS_DW-1:0] lpba_reg;
   logic [ANPS_DW-1:0] lpba_next;
   logic [ANPS_DW-1:0] lpnp_reg;
   logic [ANPS_DW-1:0] lpnp_next;
   logic               npld_reg;
   logic               lpnpa_reg;
   logic               lpana_reg;
   logic               page_rx_d_reg;
   logic               txdis_d_reg;
   logic [ANPS_DW-1:0] rdata_reg;
   logic [ANPS_DW-1:0] rdata_next;
   logic               hit_reg;

   wire sel_lpba  = (mgmt_addr_i == ANPS_ADDR_LPBA);
   wire sel_exp   = (mgmt_addr_i == ANPS_ADDR_EXP);
   wire rd_exp    = mgmt_rd_i & sel_exp;
   wire hit       = mgmt_rd_i & (sel_lpba | sel_exp);
   // writes are decoded nowhere, so data is deliberately unused
   wire wr_unused = mgmt_wr_i & (|mgmt_wdata_i);

   // (R11) base pages only
   wire load_base = page_valid_i & ~page_is_next_i;
   wire load_next = page_valid_i & page_is_next_i;

   // (R01) (R02) (R03) (R04) whole base page word captured
   // (R05) (R06) (R07) (R08) (R09) (R10) ability and selector bits
   assign lpba_next = load_base ? page_word_i : lpba_reg;
   assign lpnp_next = load_next ? page_word_i : lpnp_reg;

   // (R18) edge of page_rx falling or tx disable rising
   wire prx_fall  = page_rx_d_reg & ~mr_page_rx_i;
   wire txd_rise  = ~txdis_d_reg & transmit_disable_i;
   wire alt_clr   = alt_np_enable_i & (prx_fall | txd_rise);

   logic base_q;
   logic pdf_q;
   logic prx_q;

   // (R12) base_page tracked only in alternate mode
   wire base_set  = alt_np_enable_i & base_page_i;

   // (R12) (R21) latching base page flag
   anps_latch_high u_base (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .set_i      (base_set),
      .clr_i      (rd_exp),
      .q_o        (base_q)
   );

   // (R13) (R21) latching parallel detection fault
   anps_latch_high u_pdf (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .set_i      (pd_fault_i),
      .clr_i      (rd_exp),
      .q_o        (pdf_q)
   );

   // (R16) (R17) (R18) page received, set by any code word
   anps_latch_high u_prx (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .set_i      (page_valid_i),
      .clr_i      (rd_exp | alt_clr),
      .q_o        (prx_q)
   );

   // (R20) reserved bits zero, (R15) local ability constant
   wire [ANPS_DW-1:0] exp_word = {ANPS_EX_RSVD, base_q, pdf_q, lpnpa_reg,
                                  LOCAL_NP_ABLE, prx_q, lpana_reg};

   // (R22) reads only; unmapped addresses return zero
   assign rdata_next = !mgmt_rd_i ? rdata_reg :
                       sel_lpba   ? lpba_reg  :
                       sel_exp    ? exp_word  : '0;

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         lpba_reg      <= ANPS_LPBA_RST;
         lpnp_reg      <= ANPS_LPNP_RST;
         npld_reg      <= 1'b0;
         lpnpa_reg     <= 1'b0;
         lpana_reg     <= 1'b0;
         page_rx_d_reg <= 1'b0;
         txdis_d_reg   <= 1'b0;
         rdata_reg     <= '0;
         hit_reg       <= 1'b0;
      end else begin
         lpba_reg      <= lpba_next;
         lpnp_reg      <= lpnp_next;
         npld_reg      <= load_next;
         // (R14) (R19) partner abilities follow arbitration
         lpnpa_reg     <= lp_np_able_i;
         lpana_reg     <= lp_an_able_i;
         page_rx_d_reg <= mr_page_rx_i;
         txdis_d_reg   <= transmit_disable_i;
         rdata_reg     <= rdata_next;
         hit_reg       <= hit;
      end
   end

   assign mgmt_rdata_o        = rdata_reg;
   assign mgmt_hit_o          = hit_reg;
   assign lp_next_page_o      = lpnp_reg;
   assign lp_next_page_load_o = npld_reg;

   // checks
   property p_base_load; // (R11)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      load_base |=> (lpba_reg == $past(page_word_i));
   endproperty
   a_base_load: assert property (p_base_load) // (R11)
      else $error("base page not loaded");

   property p_next_skip; // (R11)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      load_next |=> $stable(lpba_reg) && lp_next_page_load_o;
   endproperty
   a_next_skip: assert property (p_next_skip) // (R11)
      else $error("next page disturbed base register");

   property p_prx_set; // (R16)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      page_valid_i |=> prx_q;
   endproperty
   a_prx_set: assert property (p_prx_set) // (R16)
      else $error("page received not latched");

   property p_prx_rdclr; // (R17)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      rd_exp && !page_valid_i |=> !prx_q;
   endproperty
   a_prx_rdclr: assert property (p_prx_rdclr) // (R17)
      else $error("page received not cleared on read");

   property p_alt_clr; // (R18)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      alt_np_enable_i && prx_fall && !page_valid_i |=> !prx_q;
   endproperty
   a_alt_clr: assert property (p_alt_clr) // (R18)
      else $error("alternate clear missed");

   property p_pdf_hold; // (R13)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      pdf_q && !rd_exp |=> pdf_q;
   endproperty
   a_pdf_hold: assert property (p_pdf_hold) // (R13)
      else $error("fault flag lost before read");

   property p_rsvd; // (R20)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      rd_exp |=> (mgmt_rdata_o[ANPS_DW-1:ANPS_EX_BASE+1] == ANPS_EX_RSVD)
                 && (mgmt_rdata_o[ANPS_EX_NPA] == LOCAL_NP_ABLE);
   endproperty
   a_rsvd: assert property (p_rsvd) // (R20)
      else $error("expansion constant bits wrong");

   property p_base_alt; // (R12)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !alt_np_enable_i && !base_q ##1 !alt_np_enable_i |-> !base_q;
   endproperty
   a_base_alt: assert property (p_base_alt) // (R12)
      else $error("base page flag set outside alternate mode");

   property p_nowrite; // (R22)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      mgmt_wr_i && !page_valid_i |=> $stable(lpba_reg);
   endproperty
   a_nowrite: assert property (p_nowrite) // (R22)
      else $error("write changed partner register");

   property p_reset; // (R03)
      @(posedge core_clk_i)
      !rst_n_i |=> (lpba_reg == ANPS_LPBA_RST) && !mgmt_hit_o
                   && !lp_next_page_load_o && !base_q && !pdf_q && !prx_q;
   endproperty
   a_reset: assert property (p_reset) // (R03)
      else $error("state not cleared by reset");

   property p_base_hold; // (R01)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !load_base |=> $stable(lpba_reg);
   endproperty
   a_base_hold: assert property (p_base_hold) // (R01)
      else $error("partner register changed without base page");

   property p_np_load; // (R11)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      load_next |=> (lp_next_page_o == $past(page_word_i));
   endproperty
   a_np_load: assert property (p_np_load) // (R11)
      else $error("next page word not passed on");

   property p_np_hold; // (R11)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !load_next |=> $stable(lpnp_reg) && !lp_next_page_load_o;
   endproperty
   a_np_hold: assert property (p_np_hold) // (R11)
      else $error("next page store moved without next page");

   property p_rd_lpba; // (R05)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      mgmt_rd_i && sel_lpba |=> (mgmt_rdata_o == $past(lpba_reg))
                                && mgmt_hit_o;
   endproperty
   a_rd_lpba: assert property (p_rd_lpba) // (R05)
      else $error("partner register read back wrong");

   property p_rd_exp; // (R16)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      rd_exp |=> (mgmt_rdata_o[ANPS_EX_PRX] == $past(prx_q))
                 && (mgmt_rdata_o[ANPS_EX_PDF] == $past(pdf_q))
                 && (mgmt_rdata_o[ANPS_EX_BASE] == $past(base_q));
   endproperty
   a_rd_exp: assert property (p_rd_exp) // (R16)
      else $error("latched flags read back wrong");

   property p_rd_able; // (R14)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      rd_exp |=> (mgmt_rdata_o[ANPS_EX_LPNPA] == $past(lpnpa_reg))
                 && (mgmt_rdata_o[ANPS_EX_LPANA] == $past(lpana_reg));
   endproperty
   a_rd_able: assert property (p_rd_able) // (R14)
      else $error("partner ability bits read back wrong");

   property p_rd_miss; // (R22)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      mgmt_rd_i && !sel_lpba && !sel_exp |=> (mgmt_rdata_o == '0)
                                             && !mgmt_hit_o;
   endproperty
   a_rd_miss: assert property (p_rd_miss) // (R22)
      else $error("unmapped read not zero");

   property p_rd_hold; // (R22)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !mgmt_rd_i |=> $stable(mgmt_rdata_o) && !mgmt_hit_o;
   endproperty
   a_rd_hold: assert property (p_rd_hold) // (R22)
      else $error("read data moved without a read");

   property p_pdf_set; // (R13)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      pd_fault_i |=> pdf_q;
   endproperty
   a_pdf_set: assert property (p_pdf_set) // (R13)
      else $error("fault not latched");

   property p_pdf_rdclr; // (R21)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      rd_exp && !pd_fault_i |=> !pdf_q;
   endproperty
   a_pdf_rdclr: assert property (p_pdf_rdclr) // (R21)
      else $error("fault flag not cleared on read");

   property p_base_set; // (R12)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      base_set |=> base_q;
   endproperty
   a_base_set: assert property (p_base_set) // (R12)
      else $error("base page flag not latched");

   property p_base_rdclr; // (R21)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      rd_exp && !base_set |=> !base_q;
   endproperty
   a_base_rdclr: assert property (p_base_rdclr) // (R21)
      else $error("base page flag not cleared on read");

   property p_prx_hold; // (R16)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      prx_q && !rd_exp && !alt_clr |=> prx_q;
   endproperty
   a_prx_hold: assert property (p_prx_hold) // (R16)
      else $error("page received lost without a clear");

   property p_txd_clr; // (R18)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      alt_np_enable_i && txd_rise && !page_valid_i |=> !prx_q;
   endproperty
   a_txd_clr: assert property (p_txd_clr) // (R18)
      else $error("transmit disable clear missed");

   property p_noalt_keep; // (R18)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !alt_np_enable_i && prx_q && !rd_exp |=> prx_q;
   endproperty
   a_noalt_keep: assert property (p_noalt_keep) // (R18)
      else $error("page received cleared outside alternate mode");

   property p_lpana; // (R19)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      1'b1 |=> (lpana_reg == $past(lp_an_able_i));
   endproperty
   a_lpana: assert property (p_lpana) // (R19)
      else $error("partner autoneg ability not followed");

   property p_lpnpa; // (R14)
      @(posedge core_clk_i) disable iff (!rst_n_i)
      1'b1 |=> (lpnpa_reg == $past(lp_np_able_i));
   endproperty
   a_lpnpa: assert property (p_lpnpa) // (R14)
      else $error("partner next page ability not followed");
endmodule

// ===== anps_lp_model.sv
// behavioural remote link partner: received code words and abilities
`timescale 1ns/1ps
module anps_lp_model (
   input  wire logic        core_clk_i,
   output logic             page_valid_o,
   output logic             page_is_next_o,
   output logic [15:0]      page_word_o,
   output logic             np_able_o,
   output logic             an_able_o
);
   initial begin
      page_valid_o = 1'b0;
      page_is_next_o = 1'b0;
      page_word_o = 16'hFFFF;
      np_able_o = 1'b0;
      an_able_o = 1'b0;
   end
   // word only means something with the strobe, so idle shows its inverse
   task automatic send(input logic [15:0] w, input logic nx);
      @(negedge core_clk_i);
      page_valid_o = 1'b1;
      page_is_next_o = nx;
      page_word_o = w;
      @(negedge core_clk_i);
      page_valid_o = 1'b0;
      page_is_next_o = ~nx;
      page_word_o = ~w;
   endtask
   task automatic able(input logic np, input logic an);
      @(negedge core_clk_i);
      np_able_o = np;
      an_able_o = an;
   endtask
endmodule

// ===== autoneg_partner_ability_status_test.sv
// testbench for the partner ability and expansion status registers
`timescale 1ns/1ps
module autoneg_partner_ability_status_test;
   import anps_pkg::*;
   logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [4:0]  addr = 5'h00;
   logic [15:0] wdata = 16'h0000, rdata, lnp, pw;
   logic        hit, lnpl, pv, pn, npa, ana;
   logic        bp = 1'b0, pdf = 1'b0, mrx = 1'b0, txd = 1'b0, alt = 1'b0;
   int          error_cnt = 0, compares = 0, cycles = 0;
   always #2 clk = ~clk;
   anps_lp_model anps_lp_model_inst (.core_clk_i(clk), .page_valid_o(pv),
      .page_is_next_o(pn), .page_word_o(pw), .np_able_o(npa),
      .an_able_o(ana));
   anps_status_regs anps_status_regs_inst (.core_clk_i(clk), .rst_n_i(rst_n),
      .mgmt_rd_i(rd), .mgmt_wr_i(wr), .mgmt_addr_i(addr),
      .mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata), .mgmt_hit_o(hit),
      .page_valid_i(pv), .page_is_next_i(pn), .page_word_i(pw),
      .base_page_i(bp), .pd_fault_i(pdf), .lp_np_able_i(npa),
      .lp_an_able_i(ana), .mr_page_rx_i(mrx), .transmit_disable_i(txd),
      .alt_np_enable_i(alt), .lp_next_page_o(lnp),
      .lp_next_page_load_o(lnpl));
   task automatic wrap_up();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   // one read: rdata and hit are judged in the cycle after the strobe
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
      logic h;
      h = (a == ANPS_ADDR_LPBA) || (a == ANPS_ADDR_EXP);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      chk(rdata, e);
      chk({15'h0000, hit}, {15'h0000, h});
   endtask
   task automatic t_reset();
      rd_chk(ANPS_ADDR_LPBA, 16'h0000);
      rd_chk(ANPS_ADDR_EXP, 16'h0004);
   endtask
   // one base page word, read back, then the page received flag
   task automatic base_word(input logic [15:0] w);
      anps_lp_model_inst.send(w, 1'b0);
      rd_chk(ANPS_ADDR_LPBA, w);
      rd_chk(ANPS_ADDR_EXP, 16'h0006);
      rd_chk(ANPS_ADDR_EXP, 16'h0004);
   endtask
   // walking one through every field, so each bit is set and cleared
   task automatic t_base();
      base_word(16'h8000);
      base_word(16'h4000);
      base_word(16'h2000);
      base_word(16'h1000);
      base_word(16'h0800);
      base_word(16'h0400);
      base_word(16'h0200);
      base_word(16'h0100);
      base_word(16'h0080);
      base_word(16'h0040);
      base_word(16'h0020);
      base_word({11'h000, ANPS_SEL_8023});
      base_word({11'h000, ANPS_SEL_8029});
      base_word(16'h001F);
      base_word(16'h8000);
   endtask
   task automatic t_next();
      anps_lp_model_inst.send(16'hA5C3, 1'b1);
      chk({15'h0000, lnpl}, 16'h0001);
      chk(lnp, 16'hA5C3);
      rd_chk(ANPS_ADDR_LPBA, 16'h8000);
      rd_chk(ANPS_ADDR_EXP, 16'h0006);
   endtask
   task automatic t_write();
      @(negedge clk);
      wr = 1'b1;
      addr = ANPS_ADDR_LPBA;
      wdata = 16'hFFFF;
      @(negedge clk);
      addr = ANPS_ADDR_EXP;
      @(negedge clk);
      wr = 1'b0;
      rd_chk(ANPS_ADDR_LPBA, 16'h8000);
      rd_chk(ANPS_ADDR_EXP, 16'h0004);
      rd_chk(5'h1F, 16'h0000);
   endtask
   task automatic t_latch();
      @(negedge clk);
      pdf = 1'b1;
      @(negedge clk);
      pdf = 1'b0;
      rd_chk(ANPS_ADDR_EXP, 16'h0014);
      rd_chk(ANPS_ADDR_EXP, 16'h0004);
      anps_lp_model_inst.able(1'b1, 1'b1);
      repeat (2) @(negedge clk);
      rd_chk(ANPS_ADDR_EXP, 16'h000D);
      anps_lp_model_inst.able(1'b0, 1'b0);
   endtask
   // fault in the very cycle of a read: the set must win over the clear
   task automatic t_set_wins();
      @(negedge clk);
      rd = 1'b1;
      addr = ANPS_ADDR_EXP;
      pdf = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      pdf = 1'b0;
      chk(rdata, 16'h0004);
      chk({15'h0000, hit}, 16'h0001);
      rd_chk(ANPS_ADDR_EXP, 16'h0014);
      rd_chk(ANPS_ADDR_EXP, 16'h0004);
   endtask
   // base page bit only latches with the alternate mode on
   task automatic t_alt(input logic en, input logic [15:0] e);
      @(negedge clk);
      alt = en;
      bp = 1'b1;
      @(negedge clk);
      bp = 1'b0;
      rd_chk(ANPS_ADDR_EXP, e);
      rd_chk(ANPS_ADDR_EXP, 16'h0004);
   endtask
   task automatic t_alt_clr();
      // alternate mode off: the flag must wait for a read
      alt = 1'b0;
      mrx = 1'b1;
      anps_lp_model_inst.send(16'h41E1, 1'b0);
      mrx = 1'b0;
      txd = 1'b1;
      repeat (2) @(negedge clk);
      txd = 1'b0;
      rd_chk(ANPS_ADDR_EXP, 16'h0006);
      rd_chk(ANPS_ADDR_EXP, 16'h0004);
      alt = 1'b1;
      mrx = 1'b1;
      anps_lp_model_inst.send(16'h41E1, 1'b0);
      mrx = 1'b0;
      repeat (2) @(negedge clk);
      rd_chk(ANPS_ADDR_EXP, 16'h0004);
      anps_lp_model_inst.send(16'h41E1, 1'b0);
      txd = 1'b1;
      repeat (2) @(negedge clk);
      rd_chk(ANPS_ADDR_EXP, 16'h0004);
      txd = 1'b0;
   endtask
   // hang guard, well above the roughly 190 cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         wrap_up();
      end
   end
   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_base();
      t_next();
      t_write();
      t_latch();
      t_set_wins();
      t_alt(1'b1, 16'h0024);
      t_alt(1'b0, 16'h0004);
      t_alt_clr();
      wrap_up();
   end
endmodule
